// >>> verilog/divide_pkg.sv
// shared constants and types for the decimal divide unit
package divide_pkg;

  // ==========================================================
  // widths
  localparam int ADDR_W = 14;
  localparam int MAX_DIVISOR = 16;
  localparam int CNT_W = 5;
  localparam int KLEN_W = 6;
  localparam int CYC_W = 16;

  // ==========================================================
  // character layout: word mark, zones, digit
  localparam int CH_WM_BIT = 7;
  localparam int CH_BZONE_BIT = 5;
  localparam int CH_AZONE_BIT = 4;
  localparam logic [1:0] ZONE_NONE = 2'h0;
  localparam logic [1:0] ZONE_PLUS = 2'h3;
  localparam logic [1:0] ZONE_MINUS = 2'h2;
  localparam logic [3:0] DIGIT_MAX = 4'h9;

  // operation code of the divide instruction (encoding is arbitrary)
  localparam logic [7:0] OP_DIVIDE = 8'h25;

  // cycles added to the instruction length for the count
  localparam logic [CYC_W-1:0] FETCH_EXTRA = 16'h0002;

  // ==========================================================
  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
  localparam logic [CYC_W-1:0] CYC_RST = 16'h0000;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_A_RD = 4'h1,
    ST_B_RD = 4'h2,
    ST_W_RD = 4'h3,
    ST_Q_RD = 4'h4,
    ST_SUB = 4'h5,
    ST_W_WR = 4'h6,
    ST_Q_WR = 4'h7,
    ST_DONE = 4'h8
  } state_e;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } mem_req_s;

endpackage

// >>> verilog/bcd_sub_cell.sv
// one decimal digit of a ripple subtractor
`timescale 1ns/100ps
module bcd_sub_cell (
  // operands
  input wire logic [3:0] a_in,
  input wire logic [3:0] b_in,
  input wire logic borrow_in,
  // result
  output logic [3:0] diff_out,
  output logic borrow_out
);
  logic [4:0] raw;

  always_comb begin
    raw = {1'b0, a_in} - {1'b0, b_in} - {4'h0, borrow_in};
    borrow_out = raw[4];
    // wrap a negative digit back into 0..9
    diff_out = raw[4] ? 4'(raw[3:0] + 4'ha) : raw[3:0];
  end
endmodule // bcd_sub_cell

// >>> verilog/decimal_divide_unit.sv
// decimal divide unit working on character-addressed storage
`timescale 1ns/100ps
module decimal_divide_unit (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  // instruction from the sequencer
  input wire logic START_IN,
  input wire logic [7:0] OP_CODE_IN,
  input wire logic [divide_pkg::ADDR_W-1:0] A_ADDR_IN,
  input wire logic [divide_pkg::ADDR_W-1:0] B_ADDR_IN,
  input wire logic [divide_pkg::ADDR_W-1:0]
    NEXT_SEQUENTIAL_INSTRUCTION_ADDRESS_IN,
  input wire logic [3:0] INSTR_LEN_IN,
  // storage port
  output logic MEM_REQ_OUT,
  output divide_pkg::mem_req_s MEM_OUT,
  input wire logic MEM_ACK_IN,
  input wire logic [7:0] MEM_RDATA_IN,
  // status and address registers
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic OVERFLOW_OUT,
  output logic [divide_pkg::ADDR_W-1:0] I_REG_OUT,
  output logic [divide_pkg::ADDR_W-1:0] A_REG_OUT,
  output logic [divide_pkg::ADDR_W-1:0] B_REG_OUT,
  output logic [divide_pkg::CYC_W-1:0] CYCLES_OUT
);
  localparam int MD = divide_pkg::MAX_DIVISOR;
  localparam int AW = divide_pkg::ADDR_W;

  divide_pkg::state_e state_reg;
  logic [3:0] div_reg [MD];
  logic [7:0] win_reg [MD+1];
  logic [divide_pkg::CNT_W-1:0] lr_reg;
  logic [divide_pkg::CNT_W-1:0] j_reg;
  logic [divide_pkg::KLEN_W-1:0] ld_reg;
  logic [divide_pkg::KLEN_W-1:0] k_reg;
  logic [AW-1:0] b_start_reg;
  logic [AW-1:0] base_reg;
  logic [AW-1:0] units_reg;
  logic [AW-1:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] qchar_reg;
  logic [3:0] qd_reg;
  logic div_neg_reg;
  logic dvd_neg_reg;
  logic div_zero_reg;
  logic [3:0] diff [MD+1];
  logic [MD+1:0] borrow;
  logic [3:0] sub_b [MD+1];
  logic try_neg;
  logic last_step;
  logic [1:0] qzone;
  logic [1:0] rzone;
  logic [AW-1:0] qaddr;

  // ==========================================================
  // trial subtraction of divisor from the window
  assign borrow[0] = 1'b0;
  genvar g;
  generate
    for (g = 0; g <= MD; g++) begin : g_sub
      assign sub_b[g] = (g < int'(lr_reg)) ? div_reg[g % MD] : 4'h0;
      bcd_sub_cell u_cell (
        .a_in(win_reg[g][3:0]),
        .b_in(sub_b[g]),
        .borrow_in(borrow[g]),
        .diff_out(diff[g]),
        .borrow_out(borrow[g+1])
      );
    end
  endgenerate

  assign try_neg = borrow[lr_reg + 5'h01];
  assign last_step = (k_reg == ld_reg - 6'h01);
  assign qaddr = AW'(base_reg - AW'(lr_reg) - 14'h0001);
  assign qzone = (div_neg_reg ^ dvd_neg_reg) ? divide_pkg::ZONE_MINUS
                                              : divide_pkg::ZONE_PLUS;
  assign rzone = MEM_RDATA_IN[divide_pkg::CH_BZONE_BIT:
                              divide_pkg::CH_AZONE_BIT];

  // ==========================================================
  // storage port
  always_comb begin
    MEM_REQ_OUT = 1'b0;
    MEM_OUT.we = 1'b0;
    case (state_reg)
      divide_pkg::ST_A_RD, divide_pkg::ST_B_RD, divide_pkg::ST_W_RD,
      divide_pkg::ST_Q_RD: MEM_REQ_OUT = 1'b1;
      divide_pkg::ST_W_WR, divide_pkg::ST_Q_WR: begin
        MEM_REQ_OUT = 1'b1;
        MEM_OUT.we = 1'b1;
      end
      default: MEM_REQ_OUT = 1'b0;
    endcase
    MEM_OUT.addr = addr_reg;
    MEM_OUT.wdata = wdata_reg;
  end

  assign BUSY_OUT = (state_reg != divide_pkg::ST_IDLE) &&
                    (state_reg != divide_pkg::ST_DONE);

  // ==========================================================
  // sequencer
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      state_reg <= divide_pkg::ST_IDLE;
      DONE_OUT <= 1'b0;
      OVERFLOW_OUT <= 1'b0;
      addr_reg <= divide_pkg::ADDR_RST;
      wdata_reg <= 8'h00;
      I_REG_OUT <= divide_pkg::ADDR_RST;
      A_REG_OUT <= divide_pkg::ADDR_RST;
      B_REG_OUT <= divide_pkg::ADDR_RST;
      CYCLES_OUT <= divide_pkg::CYC_RST;
      lr_reg <= '0;
      j_reg <= '0;
      ld_reg <= '0;
      k_reg <= '0;
      b_start_reg <= divide_pkg::ADDR_RST;
      base_reg <= divide_pkg::ADDR_RST;
      units_reg <= divide_pkg::ADDR_RST;
      qchar_reg <= 8'h00;
      qd_reg <= 4'h0;
      div_neg_reg <= 1'b0;
      dvd_neg_reg <= 1'b0;
      div_zero_reg <= 1'b1;
    end else begin
      DONE_OUT <= 1'b0;
      if (MEM_REQ_OUT && MEM_ACK_IN) begin
        CYCLES_OUT <= CYCLES_OUT + 16'h0001;
      end
      case (state_reg)
        divide_pkg::ST_IDLE, divide_pkg::ST_DONE: begin
          if (START_IN && OP_CODE_IN == divide_pkg::OP_DIVIDE) begin
            state_reg <= divide_pkg::ST_A_RD;
            OVERFLOW_OUT <= 1'b0;
            addr_reg <= A_ADDR_IN;
            b_start_reg <= B_ADDR_IN;
            I_REG_OUT <= NEXT_SEQUENTIAL_INSTRUCTION_ADDRESS_IN;
            A_REG_OUT <= A_ADDR_IN;
            CYCLES_OUT <= 16'(INSTR_LEN_IN) + divide_pkg::FETCH_EXTRA;
            j_reg <= '0;
            div_zero_reg <= 1'b1;
          end
        end
        divide_pkg::ST_A_RD: if (MEM_ACK_IN) begin
          div_reg[j_reg[3:0]] <= MEM_RDATA_IN[3:0];
          if (MEM_RDATA_IN[3:0] != 4'h0) begin
            div_zero_reg <= 1'b0;
          end
          if (j_reg == '0) begin
            // only a lone B zone marks a negative divisor
            div_neg_reg <= (rzone == divide_pkg::ZONE_MINUS);
          end
          if (MEM_RDATA_IN[divide_pkg::CH_WM_BIT] ||
              j_reg == 5'(MD - 1)) begin
            lr_reg <= j_reg + 5'h01;
            A_REG_OUT <= AW'(addr_reg - 14'h0001);
            addr_reg <= b_start_reg;
            j_reg <= '0;
            state_reg <= divide_pkg::ST_B_RD;
          end else begin
            j_reg <= j_reg + 5'h01;
            addr_reg <= AW'(addr_reg - 14'h0001);
          end
        end
        divide_pkg::ST_B_RD: if (MEM_ACK_IN) begin
          // the zoned character ends the dividend; appended zeros count
          if (rzone != divide_pkg::ZONE_NONE) begin
            dvd_neg_reg <= (rzone == divide_pkg::ZONE_MINUS);
            units_reg <= addr_reg;
            ld_reg <= 6'(j_reg) + 6'h01;
            k_reg <= '0;
            j_reg <= '0;
            base_reg <= b_start_reg;
            addr_reg <= b_start_reg;
            if (div_zero_reg) begin
              OVERFLOW_OUT <= 1'b1;
              B_REG_OUT <= AW'(addr_reg - AW'(lr_reg) - AW'(j_reg)
                               - 14'h0002);
              DONE_OUT <= 1'b1;
              state_reg <= divide_pkg::ST_DONE;
            end else begin
              state_reg <= divide_pkg::ST_W_RD;
            end
          end else begin
            j_reg <= j_reg + 5'h01;
            addr_reg <= AW'(addr_reg + 14'h0001);
          end
        end
        divide_pkg::ST_W_RD: if (MEM_ACK_IN) begin
          win_reg[j_reg] <= MEM_RDATA_IN;
          if (j_reg == lr_reg) begin
            addr_reg <= qaddr;
            state_reg <= divide_pkg::ST_Q_RD;
          end else begin
            j_reg <= j_reg + 5'h01;
            addr_reg <= AW'(addr_reg - 14'h0001);
          end
        end
        divide_pkg::ST_Q_RD: if (MEM_ACK_IN) begin
          // counting starts from what is already there
          qchar_reg <= MEM_RDATA_IN;
          qd_reg <= MEM_RDATA_IN[3:0];
          state_reg <= divide_pkg::ST_SUB;
        end
        divide_pkg::ST_SUB: begin
          if (!try_neg) begin
            if (qd_reg == divide_pkg::DIGIT_MAX) begin
              OVERFLOW_OUT <= 1'b1;
              B_REG_OUT <= AW'(qaddr - 14'h0001);
              DONE_OUT <= 1'b1;
              state_reg <= divide_pkg::ST_DONE;
            end else begin
              qd_reg <= qd_reg + 4'h1;
              for (int i = 0; i <= MD; i++) begin
                if (i <= int'(lr_reg)) begin
                  win_reg[i][3:0] <= diff[i];
                end
              end
            end
          end else begin
            // negative try is simply not committed
            j_reg <= '0;
            addr_reg <= base_reg;
            wdata_reg <= win_reg[0];
            state_reg <= divide_pkg::ST_W_WR;
          end
        end
        divide_pkg::ST_W_WR: if (MEM_ACK_IN) begin
          if (j_reg == lr_reg) begin
            addr_reg <= qaddr;
            wdata_reg <= {qchar_reg[7:6],
                          last_step ? qzone : qchar_reg[5:4],
                          qd_reg};
            state_reg <= divide_pkg::ST_Q_WR;
          end else begin
            j_reg <= j_reg + 5'h01;
            addr_reg <= AW'(addr_reg - 14'h0001);
            wdata_reg <= win_reg[j_reg + 5'h01];
          end
        end
        divide_pkg::ST_Q_WR: if (MEM_ACK_IN) begin
          if (last_step) begin
            B_REG_OUT <= AW'(qaddr - 14'h0001);
            DONE_OUT <= 1'b1;
            state_reg <= divide_pkg::ST_DONE;
          end else begin
            k_reg <= k_reg + 6'h01;
            j_reg <= '0;
            base_reg <= AW'(base_reg + 14'h0001);
            addr_reg <= AW'(base_reg + 14'h0001);
            state_reg <= divide_pkg::ST_W_RD;
          end
        end
        default: state_reg <= divide_pkg::ST_IDLE;
      endcase
    end
  end
endmodule // decimal_divide_unit

// >>> verif/decimal_divide_unit_properties.sv
// property checker for the decimal divide unit
`timescale 1ns/100ps
module divide_checker (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  // sequencer side
  input wire logic START_IN,
  input wire logic [7:0] OP_CODE_IN,
  input wire logic [divide_pkg::ADDR_W-1:0] A_ADDR_IN,
  input wire logic [divide_pkg::ADDR_W-1:0]
    NEXT_SEQUENTIAL_INSTRUCTION_ADDRESS_IN,
  input wire logic [3:0] INSTR_LEN_IN,
  // storage side
  input wire logic MEM_REQ_OUT,
  input wire divide_pkg::mem_req_s MEM_OUT,
  input wire logic MEM_ACK_IN,
  // status
  input wire logic BUSY_OUT,
  input wire logic DONE_OUT,
  input wire logic OVERFLOW_OUT,
  input wire logic [divide_pkg::ADDR_W-1:0] I_REG_OUT,
  input wire logic [divide_pkg::CYC_W-1:0] CYCLES_OUT
);
  logic acc;
  logic [divide_pkg::ADDR_W-1:0] next_i_reg;
  logic [divide_pkg::CYC_W-1:0] cnt_reg;
  assign acc = START_IN && OP_CODE_IN == divide_pkg::OP_DIVIDE && !BUSY_OUT;
  // ====
  // shadow count of acked accesses since the accepted start
  always_ff @(posedge REF_CLK_IN) begin
    if (acc) begin
      next_i_reg <= NEXT_SEQUENTIAL_INSTRUCTION_ADDRESS_IN;
      cnt_reg <= 16'(INSTR_LEN_IN) + divide_pkg::FETCH_EXTRA;
    end else if (MEM_REQ_OUT && MEM_ACK_IN) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);
  // ====
  // properties
  a_done_single: assert property (DONE_OUT |=> !DONE_OUT)
    else $error("done longer than one cycle");
  a_start_read: assert property (acc |=> BUSY_OUT && MEM_REQ_OUT
    && !MEM_OUT.we && MEM_OUT.addr == $past(A_ADDR_IN))
    else $error("start did not read divisor units");
  a_other_op: assert property (START_IN && !BUSY_OUT
    && OP_CODE_IN != divide_pkg::OP_DIVIDE |=> !BUSY_OUT)
    else $error("foreign op code accepted");
  a_req_hold: assert property (MEM_REQ_OUT && !MEM_ACK_IN
    |=> MEM_REQ_OUT && $stable(MEM_OUT))
    else $error("request moved before ack");
  a_idle_quiet: assert property (!BUSY_OUT |-> !MEM_REQ_OUT)
    else $error("storage request while idle");
  a_end_done: assert property ($fell(BUSY_OUT) && !$past(RESET_IN)
    |-> DONE_OUT)
    else $error("busy fell without done");
  a_ovf_clear: assert property (acc |=> !OVERFLOW_OUT)
    else $error("overflow not cleared by start");
  a_ovf_keep: assert property (OVERFLOW_OUT && !acc |=> OVERFLOW_OUT)
    else $error("overflow dropped");
  a_next_addr: assert property (DONE_OUT |-> I_REG_OUT == next_i_reg)
    else $error("instruction address wrong");
  a_cycle_count: assert property (DONE_OUT |-> CYCLES_OUT == cnt_reg)
    else $error("cycle count wrong");
  c_start: cover property (acc);
  c_good: cover property (DONE_OUT && !OVERFLOW_OUT);
  c_ovf: cover property (DONE_OUT && OVERFLOW_OUT);
endmodule // divide_checker

bind decimal_divide_unit divide_checker divide_checker_i (
  .REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN), .START_IN(START_IN),
  .OP_CODE_IN(OP_CODE_IN), .A_ADDR_IN(A_ADDR_IN),
  .NEXT_SEQUENTIAL_INSTRUCTION_ADDRESS_IN(
    NEXT_SEQUENTIAL_INSTRUCTION_ADDRESS_IN),
  .INSTR_LEN_IN(INSTR_LEN_IN),
  .MEM_REQ_OUT(MEM_REQ_OUT), .MEM_OUT(MEM_OUT), .MEM_ACK_IN(MEM_ACK_IN),
  .BUSY_OUT(BUSY_OUT), .DONE_OUT(DONE_OUT), .OVERFLOW_OUT(OVERFLOW_OUT),
  .I_REG_OUT(I_REG_OUT), .CYCLES_OUT(CYCLES_OUT));

// >>> verif/store_model.sv
// behavioural character storage answering the divide unit
`timescale 1ns/100ps
module store_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // request side
  input wire logic req_in,
  input wire divide_pkg::mem_req_s m_in,
  input wire logic [3:0] lag_in,
  // answer side
  output logic ack_out,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:16383];
  logic [3:0] wait_reg;
  logic hit;
  assign hit = req_in && !ack_out && wait_reg == lag_in && !rst_in;
  // ====
  // ack after lag_in waiting cycles, one cycle wide
  always @(posedge clk_in) begin
    if (rst_in || ack_out || !req_in) begin
      wait_reg <= 4'h0;
    end else if (!hit) begin
      wait_reg <= wait_reg + 4'h1;
    end
    ack_out <= hit;
    // data toggles outside an answer so stale values never match
    if (rst_in) begin
      rdata_out <= 8'h5a;
    end else if (hit) begin
      rdata_out <= mem[m_in.addr];
      if (m_in.we) begin
        mem[m_in.addr] <= m_in.wdata;
      end
    end else begin
      rdata_out <= ~rdata_out;
    end
  end
endmodule // store_model

// >>> verif/decimal_divide_unit_tb_top.sv
// self-checking bench for the decimal divide unit
`timescale 1ns/100ps
module decimal_divide_unit_tb_top;
  localparam logic [13:0] A_U = 14'h0064;
  localparam logic [13:0] FLD = 14'h00c8;
  localparam logic [13:0] NEXT_ADDR = 14'h0123;
  logic clk, rst, start, ack, busy, done, ovf, req;
  logic [7:0] op, rdata;
  logic [13:0] a_addr, b_addr, i_reg, a_reg, b_reg;
  logic [3:0] lag, ilen;
  logic [15:0] cycles;
  logic [1:0] zr_t [3] = '{2'h0, 2'h3, 2'h2};
  divide_pkg::mem_req_s m;
  int err_total = 0;
  int n_checks = 0;
  int ticks = 0;
  decimal_divide_unit decimal_divide_unit_i (
    .REF_CLK_IN(clk), .RESET_IN(rst), .START_IN(start), .OP_CODE_IN(op),
    .A_ADDR_IN(a_addr), .B_ADDR_IN(b_addr),
    .NEXT_SEQUENTIAL_INSTRUCTION_ADDRESS_IN(NEXT_ADDR),
    .INSTR_LEN_IN(ilen), .MEM_REQ_OUT(req), .MEM_OUT(m),
    .MEM_ACK_IN(ack), .MEM_RDATA_IN(rdata), .BUSY_OUT(busy),
    .DONE_OUT(done), .OVERFLOW_OUT(ovf), .I_REG_OUT(i_reg),
    .A_REG_OUT(a_reg), .B_REG_OUT(b_reg), .CYCLES_OUT(cycles));
  store_model store_model_i (.clk_in(clk), .rst_in(rst), .req_in(req),
    .m_in(m), .lag_in(lag), .ack_out(ack), .rdata_out(rdata));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      err_total = err_total + 1;
      wrap_up();
    end
  end
  // ====
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic go(input logic [7:0] code, input logic [13:0] b);
    int n;
    @(negedge clk);
    start = 1'b1;
    op = code;
    b_addr = b;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n = n + 1;
    end
  endtask
  task automatic load(input int dvs, lr, dvd, ld, input logic [1:0] zr, zd);
    for (int i = 0; i <= lr + ld; i++) begin
      store_model_i.mem[FLD + i] = 8'h00;
    end
    for (int i = 0; i < lr; i++) store_model_i.mem[A_U - i] =
      {i == lr - 1, 1'b0, i == 0 ? zr : 2'h0, 4'(dvs / 10 ** i % 10)};
    for (int j = 0; j < ld; j++) begin
      store_model_i.mem[FLD + lr + 1 + j] = {2'h0,
        j == ld - 1 ? zd : 2'h0, 4'(dvd / 10 ** (ld - 1 - j) % 10)};
    end
  endtask
  // ====
  // scenarios
  task automatic div_ok(input int dvs, lr, dvd, ld,
                        input logic [1:0] zr, zd, input int pre);
    int q;
    int r;
    logic [1:0] qs;
    logic [7:0] got;
    logic [7:0] want;
    load(dvs, lr, dvd, ld, zr, zd);
    store_model_i.mem[FLD] = 8'(pre);
    q = dvd / dvs + pre * 10 ** (ld - 1);
    r = dvd % dvs;
    qs = ((zr == 2'h2) != (zd == 2'h2)) ? 2'h2 : 2'h3;
    go(divide_pkg::OP_DIVIDE, FLD + 14'(lr + 1));
    check(16'(done), 16'h0001);
    check(16'(ovf), 16'h0000);
    for (int i = 0; i < ld; i++) begin
      got = store_model_i.mem[FLD + i];
      want = {2'h0, i == ld - 1 ? qs : 2'h0,
              4'(q / 10 ** (ld - 1 - i) % 10)};
      check(16'(got), 16'(want));
    end
    for (int i = 0; i <= lr; i++) begin
      got = store_model_i.mem[FLD + ld + i];
      want = {2'h0, i == lr ? zd : 2'h0, 4'(r / 10 ** (lr - i) % 10)};
      check(16'(got), 16'(want));
    end
    check(16'(i_reg), 16'(NEXT_ADDR));
    check(16'(a_reg), 16'(A_U - 14'(lr)));
    check(16'(b_reg), 16'(FLD + 14'(ld - 2)));
    check(cycles, 16'(2 + int'(ilen) + lr + ld + ld * (2 * lr + 4)));
  endtask
  task automatic div_bad(input int dvs, input int junk);
    load(dvs, 1, 74, 2, 2'h0, 2'h3);
    store_model_i.mem[FLD + 1] = 8'(junk);
    go(divide_pkg::OP_DIVIDE, FLD + 14'h0002);
    check(16'(done), 16'h0001);
    check(16'(ovf), 16'h0001);
    check(16'(store_model_i.mem[FLD + 1]), 16'(junk));
    if (dvs == 0) check(16'(b_reg), 16'(FLD - 14'h0001));
  endtask
  task automatic refuse();
    go(8'h00, FLD);
    check(16'(busy), 16'h0000);
    check(16'(done), 16'h0000);
  endtask
  // ====
  // main sequence
  initial begin
    rst = 1'b1;
    start = 1'b0;
    op = 8'h00;
    a_addr = A_U;
    b_addr = FLD;
    lag = 4'h0;
    ilen = 4'h7;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    div_ok(3, 1, 74, 2, 2'h0, 2'h3, 0);
    for (int k = 0; k < 6; k++) begin
      lag = 4'(k);
      ilen = 4'(k + 4);
      div_ok(7, 1, 95, 2, zr_t[k / 2], k[0] ? 2'h2 : 2'h3, 0);
    end
    lag = 4'h3;
    div_ok(3, 1, 740, 3, 2'h3, 2'h3, 0);
    div_ok(12, 2, 1234, 4, 2'h2, 2'h3, 0);
    div_ok(3, 1, 74, 2, 2'h0, 2'h3, 1);
    div_bad(3, 5);
    div_bad(0, 0);
    refuse();
    wrap_up();
  end
endmodule // decimal_divide_unit_tb_top
